// >>> src/bsp_defs.vh
`ifndef BSP_DEFS_VH
`define BSP_DEFS_VH

// Test controller states
`define BSP_ST_TLR 4'h0
`define BSP_ST_RTI 4'h1
`define BSP_ST_SEL_DR 4'h2
`define BSP_ST_CAP_DR 4'h3
`define BSP_ST_SHIFT_DR 4'h4
`define BSP_ST_EXIT1_DR 4'h5
`define BSP_ST_PAUSE_DR 4'h6
`define BSP_ST_EXIT2_DR 4'h7
`define BSP_ST_UPD_DR 4'h8
`define BSP_ST_SEL_IR 4'h9
`define BSP_ST_CAP_IR 4'ha
`define BSP_ST_SHIFT_IR 4'hb
`define BSP_ST_EXIT1_IR 4'hc
`define BSP_ST_PAUSE_IR 4'hd
`define BSP_ST_EXIT2_IR 4'he
`define BSP_ST_UPD_IR 4'hf

// Instruction register
`define BSP_IR_W 3
`define BSP_IR_CAPTURE 3'h1
`define BSP_IR_EXTEST 3'h0
`define BSP_IR_SAMPLE 3'h1
`define BSP_IR_HIGHZ 3'h2
`define BSP_IR_IDCODE 3'h5
`define BSP_IR_BYP0 3'h6
`define BSP_IR_BYP1 3'h7

// Register widths
`define BSP_ID_W 32
`define BSP_BSR_LEN 58
`define BSP_IO_N 26
`define BSP_IN_N 5

// Synchroniser vector layout
`define BSP_SYNC_W 35
`define BSP_SY_TCK 0
`define BSP_SY_TMS 1
`define BSP_SY_TDI 2
`define BSP_SY_TRST 3
`define BSP_SY_IN_LSB 4
`define BSP_SY_IO_LSB 9
`define BSP_SYNC_RESET 35'h000000008

// Fixed chain positions
`define BSP_POS_OUT3_CTL 28
`define BSP_POS_OUT3 29

`endif

// >>> src/bsp_scan_cell.v
`timescale 1ns/1ps
`default_nettype none

module bsp_scan_cell (
  input wire sys_clk, // System clock
  input wire rst_n, // Async reset, active low
  input wire capture_en, // Load parallel value
  input wire shift_en, // Shift one stage
  input wire update_en, // Transfer to hold stage
  input wire clear_upd, // Test reset of hold stage
  input wire cap_val, // Parallel capture value
  input wire ser_in, // Serial in from upstream
  output reg ser_q_ff, // Shift stage
  output reg upd_q_ff // Hold stage
);

  // Capture and shift stage
  always @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
      ser_q_ff <= 1'b0;
    else if (capture_en)
      ser_q_ff <= cap_val;
    else if (shift_en)
      ser_q_ff <= ser_in;
  end

  // Hold stage seen by the pins
  always @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
      upd_q_ff <= 1'b0;
    else if (clear_upd)
      upd_q_ff <= 1'b0;
    else if (update_en)
      upd_q_ff <= ser_q_ff;
  end

endmodule

`default_nettype wire

// >>> src/bsp_test_port.v
`timescale 1ns/1ps
`default_nettype none

`include "bsp_defs.vh"

module bsp_test_port #(
  parameter [31:0] ID_CODE = 32'h0a5c_3001 // Arbitrary identification value
) (
  input wire sys_clk, // System clock
  input wire rst_n, // Async reset, active low
  input wire tck, // Test clock pin
  input wire tms, // Test mode select pin
  input wire tdi, // Test data in pin
  input wire trst_n, // Optional test reset pin, active low
  output reg tdo_ff, // Test data out level
  output reg tdo_oe_ff, // Test data out driven
  input wire [25:0] io_pad_in, // Two-way pins, level at pad
  output reg [25:0] io_pad_out_ff, // Two-way pins, driven level
  output reg [25:0] io_pad_oe_ff, // Two-way pins, drive enable
  input wire [25:0] io_core_out, // Core data toward two-way pins
  input wire [25:0] io_core_oe, // Core drive enables
  output reg [25:0] io_core_in_ff, // Pin levels toward the core
  input wire out3_core_out, // Core data for the three-state output
  input wire out3_core_oe, // Core enable for the three-state output
  output reg out3_pad_out_ff, // Three-state output level
  output reg out3_pad_oe_ff, // Three-state output enable
  input wire [4:0] in_pad, // Input-only pins
  output reg [4:0] in_core_ff // Input pins toward the core
);

  // Chain position of each two-way pin cell
  function integer io_pos;
    input integer i;
    begin
      if (i < 10)
        io_pos = 2 + 2 * i;
      else if (i < 21)
        io_pos = 34 + 2 * (i - 10);
      else if (i == 21)
        io_pos = 22;
      else if (i == 22)
        io_pos = 23;
      else if (i == 23)
        io_pos = 25;
      else if (i == 24)
        io_pos = 56;
      else
        io_pos = 57;
    end
  endfunction

  // Chain position of the control cell gating each two-way pin
  function integer io_ctl;
    input integer i;
    begin
      if (i < 21)
        io_ctl = io_pos(i) - 1;
      else if (i < 23)
        io_ctl = 21;
      else if (i == 23)
        io_ctl = 24;
      else
        io_ctl = 55;
    end
  endfunction

  // Chain position of each input-only pin cell
  function integer in_pos;
    input integer k;
    begin
      if (k < 2)
        in_pos = 26 + k;
      else
        in_pos = 28 + k;
    end
  endfunction

  // Level counts once second and third stage agree
  function [`BSP_SYNC_W-1:0] agree;
    input [`BSP_SYNC_W-1:0] s2;
    input [`BSP_SYNC_W-1:0] s3;
    input [`BSP_SYNC_W-1:0] lvl;
    begin
      agree = ((s2 ~^ s3) & s3) | ((s2 ^ s3) & lvl);
    end
  endfunction

  // Next state of the test controller
  function [3:0] tap_next;
    input [3:0] st;
    input m;
    begin
      case (st)
        `BSP_ST_TLR: tap_next = m ? `BSP_ST_TLR : `BSP_ST_RTI;
        `BSP_ST_RTI: tap_next = m ? `BSP_ST_SEL_DR : `BSP_ST_RTI;
        `BSP_ST_SEL_DR: tap_next = m ? `BSP_ST_SEL_IR : `BSP_ST_CAP_DR;
        `BSP_ST_CAP_DR: tap_next = m ? `BSP_ST_EXIT1_DR : `BSP_ST_SHIFT_DR;
        `BSP_ST_SHIFT_DR: tap_next = m ? `BSP_ST_EXIT1_DR : `BSP_ST_SHIFT_DR;
        `BSP_ST_EXIT1_DR: tap_next = m ? `BSP_ST_UPD_DR : `BSP_ST_PAUSE_DR;
        `BSP_ST_PAUSE_DR: tap_next = m ? `BSP_ST_EXIT2_DR : `BSP_ST_PAUSE_DR;
        `BSP_ST_EXIT2_DR: tap_next = m ? `BSP_ST_UPD_DR : `BSP_ST_SHIFT_DR;
        `BSP_ST_UPD_DR: tap_next = m ? `BSP_ST_SEL_DR : `BSP_ST_RTI;
        `BSP_ST_SEL_IR: tap_next = m ? `BSP_ST_TLR : `BSP_ST_CAP_IR;
        `BSP_ST_CAP_IR: tap_next = m ? `BSP_ST_EXIT1_IR : `BSP_ST_SHIFT_IR;
        `BSP_ST_SHIFT_IR: tap_next = m ? `BSP_ST_EXIT1_IR : `BSP_ST_SHIFT_IR;
        `BSP_ST_EXIT1_IR: tap_next = m ? `BSP_ST_UPD_IR : `BSP_ST_PAUSE_IR;
        `BSP_ST_PAUSE_IR: tap_next = m ? `BSP_ST_EXIT2_IR : `BSP_ST_PAUSE_IR;
        `BSP_ST_EXIT2_IR: tap_next = m ? `BSP_ST_UPD_IR : `BSP_ST_SHIFT_IR;
        `BSP_ST_UPD_IR: tap_next = m ? `BSP_ST_SEL_DR : `BSP_ST_RTI;
        default: tap_next = `BSP_ST_TLR;
      endcase
    end
  endfunction

  reg [`BSP_SYNC_W-1:0] sy1_ff;
  reg [`BSP_SYNC_W-1:0] sy2_ff;
  reg [`BSP_SYNC_W-1:0] sy3_ff;
  reg [`BSP_SYNC_W-1:0] lvl_ff;
  reg tck_prev_ff;
  reg [3:0] st_ff;
  reg [`BSP_IR_W-1:0] ir_sh_ff;
  reg [`BSP_IR_W-1:0] ir_ff;
  reg byp_ff;
  reg [`BSP_ID_W-1:0] id_sh_ff;
  reg [`BSP_BSR_LEN-1:0] cap_vec;
  reg [3:0] nxt_st;
  reg sel_out;
  wire [`BSP_SYNC_W-1:0] async_in;
  wire [`BSP_SYNC_W-1:0] nxt_lvl;
  wire [`BSP_BSR_LEN-1:0] bsr_q;
  wire [`BSP_BSR_LEN-1:0] bsr_upd;
  wire tck_lvl;
  wire tms_lvl;
  wire tdi_lvl;
  wire trst_act;
  wire tck_rise;
  wire tck_fall;
  wire sel_bsr;
  wire sel_id;
  wire sel_byp;
  wire mode_extest;
  wire mode_highz;
  wire cap_dr;
  wire sh_dr;
  wire upd_dr;
  wire in_tlr;
  integer i;
  integer j;

  // All pins from outside pass three stages
  assign async_in = {io_pad_in, in_pad, trst_n, tdi, tms, tck};
  assign nxt_lvl = agree(sy2_ff, sy3_ff, lvl_ff);

  always @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sy1_ff <= `BSP_SYNC_RESET;
      sy2_ff <= `BSP_SYNC_RESET;
      sy3_ff <= `BSP_SYNC_RESET;
      lvl_ff <= `BSP_SYNC_RESET;
      tck_prev_ff <= 1'b0;
    end
    else
    begin
      sy1_ff <= async_in;
      sy2_ff <= sy1_ff;
      sy3_ff <= sy2_ff;
      lvl_ff <= nxt_lvl;
      tck_prev_ff <= lvl_ff[`BSP_SY_TCK];
    end
  end

  // Filtered levels and test clock edges
  assign tck_lvl = lvl_ff[`BSP_SY_TCK];
  assign tms_lvl = lvl_ff[`BSP_SY_TMS];
  assign tdi_lvl = lvl_ff[`BSP_SY_TDI];
  assign trst_act = ~lvl_ff[`BSP_SY_TRST];
  assign tck_rise = tck_lvl & ~tck_prev_ff;
  assign tck_fall = ~tck_lvl & tck_prev_ff;

  // Controller advances on test clock rises, steered by mode select only
  always @*
  begin
    nxt_st = st_ff;
    if (tck_rise)
      nxt_st = tap_next(st_ff, tms_lvl);
  end

  always @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
      st_ff <= `BSP_ST_TLR;
    else if (trst_act)
      st_ff <= `BSP_ST_TLR;
    else
      st_ff <= nxt_st;
  end

  // Strobes for one test clock rise in a given state; in_tlr is the plain state level
  assign in_tlr = (st_ff == `BSP_ST_TLR);
  assign cap_dr = tck_rise & (st_ff == `BSP_ST_CAP_DR);
  assign sh_dr = tck_rise & (st_ff == `BSP_ST_SHIFT_DR);
  assign upd_dr = tck_rise & (st_ff == `BSP_ST_UPD_DR);

  // Instruction shift and active instruction
  always @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ir_sh_ff <= `BSP_IR_CAPTURE;
      ir_ff <= `BSP_IR_IDCODE;
    end
    else if (trst_act || in_tlr)
    begin
      ir_sh_ff <= `BSP_IR_CAPTURE;
      ir_ff <= `BSP_IR_IDCODE;
    end
    else if (tck_rise)
    begin
      case (st_ff)
        `BSP_ST_CAP_IR: ir_sh_ff <= `BSP_IR_CAPTURE;
        `BSP_ST_SHIFT_IR: ir_sh_ff <= {tdi_lvl, ir_sh_ff[`BSP_IR_W-1:1]};
        `BSP_ST_UPD_IR: ir_ff <= ir_sh_ff;
        default: ir_ff <= ir_ff;
      endcase
    end
  end

  // Instruction decode picks the data register
  assign sel_bsr = (ir_ff == `BSP_IR_EXTEST) |
                   (ir_ff == `BSP_IR_SAMPLE);
  assign sel_id = (ir_ff == `BSP_IR_IDCODE);
  assign sel_byp = ~sel_bsr & ~sel_id;
  assign mode_extest = (ir_ff == `BSP_IR_EXTEST);
  assign mode_highz = (ir_ff == `BSP_IR_HIGHZ);

  // Bypass stage and identification register
  always @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      byp_ff <= 1'b0;
      id_sh_ff <= {`BSP_ID_W{1'b0}};
    end
    else
    begin
      if (cap_dr && sel_byp)
        byp_ff <= 1'b0;
      else if (sh_dr && sel_byp)
        byp_ff <= tdi_lvl;
      if (cap_dr && sel_id)
        id_sh_ff <= ID_CODE;
      else if (sh_dr && sel_id)
        id_sh_ff <= {tdi_lvl, id_sh_ff[`BSP_ID_W-1:1]};
    end
  end

  // Parallel values captured into the boundary chain
  always @*
  begin
    cap_vec = {`BSP_BSR_LEN{1'b0}}; // Linkage cell captures zero
    for (i = 0; i < `BSP_IO_N; i = i + 1)
    begin
      cap_vec[io_pos(i)] = lvl_ff[`BSP_SY_IO_LSB + i];
      cap_vec[io_ctl(i)] = io_core_oe[i];
    end
    for (i = 0; i < `BSP_IN_N; i = i + 1)
      cap_vec[in_pos(i)] = lvl_ff[`BSP_SY_IN_LSB + i];
    cap_vec[`BSP_POS_OUT3_CTL] = out3_core_oe;
    cap_vec[`BSP_POS_OUT3] = out3_core_out;
  end

  // Cells chained with position 0 nearest data out
  genvar g;
  generate
    for (g = 0; g < `BSP_BSR_LEN; g = g + 1)
    begin : chain
      wire ser_in;
      if (g == `BSP_BSR_LEN - 1)
      begin : head
        assign ser_in = tdi_lvl;
      end
      else
      begin : link
        assign ser_in = bsr_q[g + 1];
      end
      bsp_scan_cell u_cell (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .capture_en(cap_dr & sel_bsr),
        .shift_en(sh_dr & sel_bsr),
        .update_en(upd_dr & sel_bsr),
        .clear_upd(in_tlr),
        .cap_val(cap_vec[g]),
        .ser_in(ser_in),
        .ser_q_ff(bsr_q[g]),
        .upd_q_ff(bsr_upd[g])
      );
    end
  endgenerate

  // Register in path for the falling-edge data out
  always @*
  begin
    if (st_ff == `BSP_ST_SHIFT_IR)
      sel_out = ir_sh_ff[0];
    else if (sel_bsr)
      sel_out = bsr_q[0];
    else if (sel_id)
      sel_out = id_sh_ff[0];
    else
      sel_out = byp_ff;
  end

  always @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      tdo_ff <= 1'b0;
      tdo_oe_ff <= 1'b0;
    end
    else if (tck_fall)
    begin
      tdo_ff <= sel_out;
      tdo_oe_ff <= (st_ff == `BSP_ST_SHIFT_IR) |
                   (st_ff == `BSP_ST_SHIFT_DR);
    end
  end

  // Pin drive: core path, cell drive, or all released
  always @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      io_pad_out_ff <= 26'h0000000;
      io_pad_oe_ff <= 26'h0000000;
      out3_pad_out_ff <= 1'b0;
      out3_pad_oe_ff <= 1'b0;
    end
    else
    begin
      for (j = 0; j < `BSP_IO_N; j = j + 1)
      begin
        if (mode_highz)
        begin
          io_pad_out_ff[j] <= 1'b0;
          io_pad_oe_ff[j] <= 1'b0;
        end
        else if (mode_extest)
        begin
          io_pad_out_ff[j] <= bsr_upd[io_pos(j)];
          io_pad_oe_ff[j] <= bsr_upd[io_ctl(j)];
        end
        else
        begin
          io_pad_out_ff[j] <= io_core_out[j];
          io_pad_oe_ff[j] <= io_core_oe[j];
        end
      end
      if (mode_highz)
      begin
        out3_pad_out_ff <= 1'b0;
        out3_pad_oe_ff <= 1'b0;
      end
      else if (mode_extest)
      begin
        out3_pad_out_ff <= bsr_upd[`BSP_POS_OUT3];
        out3_pad_oe_ff <= bsr_upd[`BSP_POS_OUT3_CTL];
      end
      else
      begin
        out3_pad_out_ff <= out3_core_out;
        out3_pad_oe_ff <= out3_core_oe;
      end
    end
  end

  // Pin levels handed to the core
  always @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      io_core_in_ff <= 26'h0000000;
      in_core_ff <= 5'h00;
    end
    else
    begin
      io_core_in_ff <= lvl_ff[`BSP_SY_IO_LSB +: `BSP_IO_N];
      in_core_ff <= lvl_ff[`BSP_SY_IN_LSB +: `BSP_IN_N];
    end
  end

endmodule

`default_nettype wire

// >>> dv/bsp_test_port_monitor.sv
`timescale 1ns/1ps
`default_nettype none

module bsp_test_port_monitor (
  input wire logic sys_clk, // System clock
  input wire logic rst_n, // Reset, active low
  input wire logic tck, // Test clock pin
  input wire logic trst_n, // Test reset pin, active low
  input wire logic tdo_ff, // Test data out
  input wire logic tdo_oe_ff, // Test data out driven
  input wire logic [25:0] io_pad_in, // Pad levels
  input wire logic [25:0] io_pad_oe_ff, // Pad drive enables
  input wire logic [25:0] io_core_oe, // Core drive enables
  input wire logic [25:0] io_core_in_ff, // Pad levels to core
  input wire logic [4:0] in_pad, // Input-only pins
  input wire logic [4:0] in_core_ff // Input pins to core
);
  logic [3:0] lo_cnt_ff;

  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  // Clocks since the test clock was last seen high, saturating
  always_ff @(posedge sys_clk or negedge rst_n)
    if (!rst_n)
      lo_cnt_ff <= 4'h0;
    else if (tck)
      lo_cnt_ff <= 4'h0;
    else if (lo_cnt_ff != 4'hf)
      lo_cnt_ff <= lo_cnt_ff + 4'h1;

  property p_tdo_on_fall;
    $changed(tdo_ff) |-> lo_cnt_ff inside {[2:7]};
  endproperty
  a_tdo_on_fall: assert property (p_tdo_on_fall)
    else $error("data out moved away from a test clock fall");

  property p_oe_rise;
    $rose(tdo_oe_ff) |-> lo_cnt_ff inside {[2:7]};
  endproperty
  a_oe_rise: assert property (p_oe_rise)
    else $error("data out drive began away from a fall");

  property p_oe_fall;
    $fell(tdo_oe_ff) |-> lo_cnt_ff inside {[2:7]};
  endproperty
  a_oe_fall: assert property (p_oe_fall)
    else $error("data out drive ended away from a fall");

  property p_share_a;
    $past(io_core_oe[21]) == $past(io_core_oe[22])
      |-> io_pad_oe_ff[21] == io_pad_oe_ff[22];
  endproperty
  a_share_a: assert property (p_share_a)
    else $error("frame and clock pins of bus a split");

  property p_share_b;
    $past(io_core_oe[24]) == $past(io_core_oe[25])
      |-> io_pad_oe_ff[24] == io_pad_oe_ff[25];
  endproperty
  a_share_b: assert property (p_share_b)
    else $error("frame and clock pins of bus b split");

  property p_in_follow;
    $stable(in_pad) [*8] |-> in_core_ff == in_pad;
  endproperty
  a_in_follow: assert property (p_in_follow)
    else $error("input pins not passed to core");

  property p_io_follow;
    $stable(io_pad_in) [*8] |-> io_core_in_ff == io_pad_in;
  endproperty
  a_io_follow: assert property (p_io_follow)
    else $error("two-way pin levels not passed to core");

  property p_oe_cause;
    $changed(io_pad_oe_ff) |-> tck || $past(tck) || $past(tck, 2) || !trst_n
      || !$past(rst_n, 4) || $past(io_core_oe) != $past(io_core_oe, 2);
  endproperty
  a_oe_cause: assert property (p_oe_cause)
    else $error("pad enables moved without a cause");
endmodule

bind bsp_test_port bsp_test_port_monitor mon_u (.sys_clk, .rst_n, .tck,
  .trst_n, .tdo_ff, .tdo_oe_ff, .io_pad_in, .io_pad_oe_ff, .io_core_oe,
  .io_core_in_ff, .in_pad, .in_core_ff);

`default_nettype wire

// >>> dv/bsp_tester.sv
`timescale 1ns/1ps
`default_nettype none

module bsp_tester (
  input wire logic sys_clk, // System clock
  input wire logic tdo_ff, // Data out of device
  input wire logic tdo_oe_ff, // Data out driven
  output logic tck, // Test clock
  output logic tms, // Mode select
  output logic tdi, // Data in
  output logic trst_n // Test reset, active low
);
  logic tdo_last;
  int acc;
  // Released line shows a changing level
  wire logic tdo_w = tdo_oe_ff ? tdo_ff : ~tdo_last;

  initial
  begin
    tck = 1'b0;
    tms = 1'b1;
    tdi = 1'b0;
    trst_n = 1'b1;
    acc = 0;
    tdo_last = 1'b0;
  end

  // Last seen data out level
  always @(posedge sys_clk)
    tdo_last <= tdo_w;

  // Half of a 64 ns test clock on the 5 ns grid
  task automatic half();
    do
    begin
      @(posedge sys_clk);
      acc += 5;
    end
    while (acc < 32);
    acc -= 32;
  endtask

  // One test clock; data out read late in the high phase
  task automatic step(input logic m, input logic d, output logic q);
    tms <= m;
    tdi <= d;
    half();
    tck <= 1'b1;
    half();
    q = tdo_w;
    tck <= 1'b0;
  endtask

  // Pulse the optional test reset
  task automatic test_reset();
    trst_n <= 1'b0;
    repeat (10) @(posedge sys_clk);
    trst_n <= 1'b1;
    repeat (10) @(posedge sys_clk);
  endtask
endmodule

`default_nettype wire

// >>> dv/boundary_scan_test_port_tb_top.sv
`timescale 1ns/1ps
`default_nettype none

module boundary_scan_test_port_tb_top;
  localparam logic [31:0] ID_VAL = 32'h5e1d_07c3; // Arbitrary value
  localparam logic [71:0] DIN = 72'hc3;
  localparam logic [57:0] PAT = 58'h2c5_a39e_61b4_d78f;
  logic sys_clk, rst_n, tck, tms, tdi, trst_n, tdo_ff, tdo_oe_ff, q;
  logic out3_core_out, out3_core_oe, out3_pad_out_ff, out3_pad_oe_ff;
  logic [25:0] io_pad_in, io_pad_out_ff, io_pad_oe_ff, io_core_out;
  logic [25:0] io_core_oe, io_core_in_ff, ext_drv, e_oe, e_out;
  logic [4:0] in_pad, in_core_ff;
  logic [71:0] dout;
  logic [71:0] row_exp [8];
  logic [71:0] row_msk [8];
  logic [2:0] row_ir [8] = '{3'h1, 3'h5, 3'h6, 3'h7, 3'h3, 3'h4, 3'h2, 3'h0};
  int row_n [8] = '{66, 40, 9, 9, 9, 9, 9, 66};
  int in_pos [5] = '{26, 27, 30, 31, 32};
  int error_cnt, cmp_count, cyc;

  // Pad level: device drive where enabled, else the board
  assign io_pad_in = (io_pad_oe_ff & io_pad_out_ff) | (~io_pad_oe_ff & ext_drv);

  bsp_test_port #(.ID_CODE(ID_VAL)) dut_u (.sys_clk, .rst_n, .tck, .tms,
    .tdi, .trst_n, .tdo_ff, .tdo_oe_ff, .io_pad_in, .io_pad_out_ff,
    .io_pad_oe_ff, .io_core_out, .io_core_oe, .io_core_in_ff, .out3_core_out,
    .out3_core_oe, .out3_pad_out_ff, .out3_pad_oe_ff, .in_pad, .in_core_ff);

  bsp_tester tester_u (.sys_clk, .tdo_ff, .tdo_oe_ff, .tck, .tms, .tdi,
    .trst_n);

  // System clock
  initial
  begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end

  // Cut a hung run short
  always @(posedge sys_clk)
  begin
    cyc++;
    if (cyc == 60000)
    begin
      error_cnt++;
      finish_test();
    end
  end

  task automatic check(input string what, input logic [71:0] seen,
    input logic [71:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  // From idle: capture, shift n bits first bit first, update, idle
  task automatic scan(input logic ir, input int n, input logic [71:0] din,
    output logic [71:0] dq);
    logic b;
    dq = '0;
    tester_u.step(1'b1, 1'b0, b);
    if (ir)
      tester_u.step(1'b1, 1'b0, b);
    tester_u.step(1'b0, 1'b0, b);
    tester_u.step(1'b0, 1'b0, b);
    for (int i = 0; i < n; i++)
    begin
      tester_u.step(i == n - 1, din[i], b);
      dq[i] = b;
    end
    tester_u.step(1'b1, 1'b0, b);
    tester_u.step(1'b0, 1'b0, b);
  endtask

  task automatic load_ir(input logic [2:0] code);
    scan(1'b1, 3, {69'h0, code}, dout);
    check("instruction capture", dout[2:0], 3'b001);
  endtask

  // Pins back on the core path and identification selected
  task automatic after_reset();
    tester_u.step(1'b0, 1'b0, q);
    check("enables after reset", {out3_pad_oe_ff, io_pad_oe_ff},
      {1'b1, io_core_oe});
    scan(1'b0, 32, DIN, dout);
    check("id after reset", dout[31:0], ID_VAL);
  endtask

  function automatic int pin_pos(int i);
    int hi [5] = '{22, 23, 25, 56, 57};
    if (i < 10)
      return 2 + 2 * i;
    if (i < 21)
      return 34 + 2 * (i - 10);
    return hi[i - 21];
  endfunction

  function automatic int ctl_pos(int i);
    if (i < 21)
      return pin_pos(i) - 1;
    if (i < 23)
      return 21;
    return (i == 23) ? 24 : 55;
  endfunction

  // Boundary capture for the given two-way pad levels
  function automatic logic [57:0] sample_cap(input logic [25:0] pads);
    logic [57:0] c;
    c = '0;
    for (int i = 0; i < 26; i++)
    begin
      c[pin_pos(i)] = pads[i];
      c[ctl_pos(i)] = io_core_oe[i];
    end
    foreach (in_pos[k])
      c[in_pos[k]] = in_pad[k];
    c[28] = out3_core_oe;
    c[29] = out3_core_out;
    return c;
  endfunction

  // Main sequence
  initial
  begin
    rst_n <= 1'b0;
    io_core_out <= 26'h2a5_c3e1;
    io_core_oe <= '1;
    ext_drv <= 26'h1b3_4c2d;
    in_pad <= 5'h15;
    out3_core_out <= 1'b1;
    out3_core_oe <= 1'b1;
    repeat (12) @(posedge sys_clk);
    check("outputs in reset", {tdo_oe_ff, out3_pad_oe_ff, io_pad_oe_ff},
      72'h0);
    rst_n <= 1'b1;
    repeat (10) @(posedge sys_clk);
    tester_u.step(1'b0, 1'b0, q);
    // Extest row: hold cells still zero, so two-way pads show the board
    row_exp = '{{DIN[7:0], sample_cap(io_core_out)}, {DIN[7:0], ID_VAL},
      {DIN[7:0], 1'b0}, {DIN[7:0], 1'b0}, {DIN[7:0], 1'b0},
      {DIN[7:0], 1'b0}, {DIN[7:0], 1'b0}, {DIN[7:0], sample_cap(ext_drv)}};
    row_msk = '{{66{1'b1}}, {40{1'b1}}, 72'h1ff, 72'h1ff, 72'h1ff, 72'h1ff,
      72'h1ff, {66{1'b1}}};
    for (int r = 0; r < 8; r++)
    begin
      load_ir(row_ir[r]);
      scan(1'b0, row_n[r], DIN, dout);
      check("data path", dout & row_msk[r],
        row_exp[r] & row_msk[r]);
      if (row_ir[r] != 3'h0)
        check("pad enables", {out3_pad_oe_ff, io_pad_oe_ff},
          row_ir[r] == 3'h2 ? 72'h0 : {1'b1, io_core_oe});
    end
    scan(1'b0, 58, {14'h0, PAT}, dout);
    repeat (3) @(posedge sys_clk);
    for (int i = 0; i < 26; i++)
    begin
      e_oe[i] = PAT[ctl_pos(i)];
      e_out[i] = PAT[pin_pos(i)];
    end
    check("extest enables", {out3_pad_oe_ff, io_pad_oe_ff},
      {PAT[28], e_oe});
    check("extest levels", {out3_pad_out_ff, io_pad_out_ff & e_oe},
      {PAT[29], e_out & e_oe});
    repeat (5) tester_u.step(1'b1, 1'b0, q);
    after_reset();
    load_ir(3'h2);
    tester_u.test_reset();
    after_reset();
    finish_test();
  end
endmodule

`default_nettype wire
